/* include/cm_fill_pkg.sv */
// Purpose: constants for the connection memory and its block fill engine
// Assumes: one clock, synchronous active-high reset
// Notes: frame length is counted in clk cycles at 100 mhz
//
// Summary of operation
// [RQ1] each output channel has a 16-bit low word and a 5-bit high word
// [RQ2] coding enable low: no law conversion, high word ignored for channel
// [RQ3] host reads or writes any low or high word in one access cycle
// [RQ4] unimplemented data bits read back as zero
// [RQ5] special mode clear: switch from source channel bits 8-1, stream 13-9
// [RQ6] host writes high word before setting the coding enable bit
// [RQ7] message mode sends low-word bits 10-3 as the channel output byte
// [RQ8] message mode still applies law conversion when coding enable set
// [RQ9] host raises fill enable before starting a fill
// [RQ10] host then writes the 3-bit fill pattern
// [RQ11] fill writes pattern to low bits 2-0, zeroes the rest and high word
// [RQ12] high word bits 15-5 are reserved and always zero
// [RQ13] a fill takes at least two frame periods
// [RQ14] fill start bit clears itself when the fill completes
// [RQ15] host clears fill enable after a fill; device never does
// [RQ16] dropping fill start or fill enable aborts a running fill
// [RQ17] after an enable abort host clears fill start before other work
// [RQ18] host sets variable delay global enable before per-channel bit 14
// [RQ19] bit 14 low in normal mode selects constant throughput delay
// [RQ20] fill start set while fill enable low is ignored
package cm_fill_pkg;
  localparam int unsigned CHAN_CNT = 2048;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned LOW_W = 16;
  localparam int unsigned HIGH_W = 5;
  // low word fields
  localparam int unsigned SPECIAL_BIT = 0;
  localparam int unsigned SRC_CH_LSB = 1;
  localparam int unsigned SRC_ST_LSB = 9;
  localparam int unsigned MSG_LSB = 3;
  localparam int unsigned VAR_DELAY_BIT = 14;
  localparam int unsigned CODING_EN_BIT = 15;
  // control bits
  localparam int unsigned FILL_EN_BIT = 3;
  localparam int unsigned VAR_EN_BIT = 4;
  localparam int unsigned FILL_START_BIT = 0;
  localparam int unsigned PATTERN_LSB = 1;
  // timing: frame is 125 us
  localparam int unsigned FRAME_NS = 125000;
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned FRAME_CYC = FRAME_NS / CLK_NS;
  localparam int unsigned FILL_MIN_CYC = 2 * FRAME_CYC;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  typedef enum logic [1:0] {FILL_IDLE, FILL_RUN, FILL_HOLD} fill_state_t;
endpackage : cm_fill_pkg

/* rtl/cm_fill.sv */
// Purpose: connection memory with host port, channel readout and block fill
// Assumes: host access is synchronous; high_sel picks the high word block
// Notes: fill sweeps one location per clock, then holds until it has lasted FILL_CYC clocks in all, two frames by default
`timescale 1ns/100ps
`default_nettype none
module cm_fill #(
  parameter int unsigned FILL_CYC = cm_fill_pkg::FILL_MIN_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic cs,
  input wire logic wr,
  input wire logic high_sel,
  input wire logic [10:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata,
  output logic ack,
  input wire logic ctrl_wr,
  input wire logic [15:0] ctrl_wdata,
  input wire logic mode_wr,
  input wire logic [15:0] mode_wdata,
  output logic [15:0] main_control_register,
  output logic [15:0] internal_mode_register,
  input wire logic [10:0] chan_sel,
  output logic special_mode_select,
  output logic [7:0] source_channel_field,
  output logic [4:0] source_stream_field,
  output logic [7:0] message_byte_field,
  output logic coding_conversion_enable,
  output logic [4:0] coding_law,
  output logic variable_delay,
  output logic fill_busy
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [15:0] low_mem [0:cm_fill_pkg::CHAN_CNT-1]; // [RQ1]
  logic [4:0] high_mem [0:cm_fill_pkg::CHAN_CNT-1];
  logic [15:0] ctrl_r, ctrl_nxt, mode_r, mode_nxt, rdata_r, rdata_nxt;
  logic ack_r, ack_nxt;
  cm_fill_pkg::fill_state_t st_r, st_nxt;
  logic [10:0] fa_r, fa_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [31:0] busy_len_r, busy_len_nxt;
  logic fill_en, fill_go, abort, fill_wr;
  logic [15:0] lw;
  logic [4:0] hw;

  assign fill_en = ctrl_r[cm_fill_pkg::FILL_EN_BIT];
  assign fill_go = mode_r[cm_fill_pkg::FILL_START_BIT];
  assign abort = !fill_en || !fill_go; // [RQ16]
  assign fill_wr = (st_r == cm_fill_pkg::FILL_RUN) && !abort;

  // ------------------------------------------------------------
  // control, fill engine and host port
  // ------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    mode_nxt = mode_r;
    st_nxt = st_r;
    fa_nxt = fa_r;
    cnt_nxt = cnt_r;
    ack_nxt = cs && !ack_r; // [RQ3]
    rdata_nxt = rdata_r;
    if (ctrl_wr) begin
      ctrl_nxt = ctrl_wdata;
    end
    if (mode_wr) begin
      mode_nxt = mode_wdata;
      // a start with fill enable low is dropped
      if (!fill_en) begin
        mode_nxt[cm_fill_pkg::FILL_START_BIT] = 1'b0; // [RQ20]
      end
    end
    if (cs && !wr && !ack_r) begin
      if (high_sel) begin
        rdata_nxt = {11'h000, high_mem[addr]}; // [RQ4] [RQ12]
      end else begin
        rdata_nxt = low_mem[addr];
      end
    end
    case (st_r)
      cm_fill_pkg::FILL_IDLE: begin
        fa_nxt = 11'h000;
        cnt_nxt = 32'h0;
        if (fill_en && fill_go) begin
          st_nxt = cm_fill_pkg::FILL_RUN;
        end
      end
      cm_fill_pkg::FILL_RUN, cm_fill_pkg::FILL_HOLD: begin
        cnt_nxt = cnt_r + 32'h1;
        if (st_r == cm_fill_pkg::FILL_RUN) begin
          fa_nxt = fa_r + 11'h1;
          if (fa_r == 11'h7ff) begin
            st_nxt = cm_fill_pkg::FILL_HOLD;
          end
        end else if (cnt_r >= FILL_CYC - 1) begin // [RQ13]
          st_nxt = cm_fill_pkg::FILL_IDLE;
          // a host mode write in the same cycle wins over the self-clear
          if (!mode_wr) begin
            mode_nxt[cm_fill_pkg::FILL_START_BIT] = 1'b0; // [RQ14]
          end
        end
        if (abort) begin
          st_nxt = cm_fill_pkg::FILL_IDLE; // [RQ16]
        end
      end
      default: begin
        st_nxt = cm_fill_pkg::FILL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_r <= cm_fill_pkg::CTRL_RESET;
      mode_r <= cm_fill_pkg::CTRL_RESET;
      st_r <= cm_fill_pkg::FILL_IDLE;
      fa_r <= 11'h000;
      cnt_r <= 32'h0;
      ack_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      mode_r <= mode_nxt;
      st_r <= st_nxt;
      fa_r <= fa_nxt;
      cnt_r <= cnt_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // memory writes: fill has priority, host writes during the sweep are lost, those during the hold go through
  always_ff @(posedge clk) begin
    if (fill_wr) begin
      low_mem[fa_r] <= {13'h0000, mode_r[3:1]}; // [RQ11]
      high_mem[fa_r] <= 5'h00;
    end else if (cs && wr && !ack_r) begin // [RQ3]
      if (high_sel) begin
        high_mem[addr] <= wdata[4:0]; // [RQ12]
      end else begin
        low_mem[addr] <= wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // per-channel readout to the switching core
  // ------------------------------------------------------------
  assign lw = low_mem[chan_sel];
  assign hw = high_mem[chan_sel];
  always_ff @(posedge clk) begin
    if (srst) begin
      special_mode_select <= 1'b0;
      source_channel_field <= 8'h00;
      source_stream_field <= 5'h00;
      message_byte_field <= 8'h00;
      coding_conversion_enable <= 1'b0;
      coding_law <= 5'h00;
      variable_delay <= 1'b0;
    end else begin
      special_mode_select <= lw[cm_fill_pkg::SPECIAL_BIT];
      source_channel_field <= lw[8:1]; // [RQ5]
      source_stream_field <= lw[13:9];
      message_byte_field <= lw[10:3]; // [RQ7]
      // conversion applies in message mode too
      coding_conversion_enable <= lw[cm_fill_pkg::CODING_EN_BIT]; // [RQ8]
      coding_law <= lw[cm_fill_pkg::CODING_EN_BIT] ? hw : 5'h00; // [RQ2]
      // constant delay unless bit set in normal mode; global enable is
      // the host's duty, so it is not gated here
      variable_delay <= !lw[cm_fill_pkg::SPECIAL_BIT] &&
        lw[cm_fill_pkg::VAR_DELAY_BIT]; // [RQ19]
    end
  end

  assign rdata = rdata_r;
  assign ack = ack_r;
  assign main_control_register = ctrl_r;
  assign internal_mode_register = mode_r;
  assign fill_busy = (st_r != cm_fill_pkg::FILL_IDLE);

  // ------------------------------------------------------------
  // busy length monitor
  // ------------------------------------------------------------
  // counted apart from cnt_r so the length check does not lean on the
  // very counter that it guards
  always_comb begin
    busy_len_nxt = fill_busy ? busy_len_r + 32'h1 : 32'h0;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      busy_len_r <= 32'h0;
    end else begin
      busy_len_r <= busy_len_nxt;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // only a completed fill clears start and busy together; aborts do not
  chk_fill_min_len: assert property (@(posedge clk) disable iff (srst) // [RQ13]
    $fell(fill_busy) && $fell(fill_go) |-> busy_len_r >= FILL_CYC)
    else $error("fill ended too early");
  chk_fill_selfclr: assert property (@(posedge clk) disable iff (srst) // [RQ14]
    $fell(fill_busy) && fill_en && !$past(mode_wr) |-> !fill_go)
    else $error("fill start not cleared");
  chk_fill_abort: assert property (@(posedge clk) disable iff (srst) // [RQ16]
    fill_busy && !fill_en |=> !fill_busy)
    else $error("fill not aborted");
  chk_start_gate: assert property (@(posedge clk) disable iff (srst) // [RQ20]
    mode_wr && !fill_en |=> !fill_go)
    else $error("start taken without enable");
  chk_ack_one: assert property (@(posedge clk) disable iff (srst) // [RQ3]
    cs && !ack |=> ack)
    else $error("access not acknowledged");
  chk_high_zero: assert property (@(posedge clk) disable iff (srst) // [RQ4]
    ack && $past(high_sel) && !$past(wr) |-> rdata[15:5] == 11'h000)
    else $error("reserved bits nonzero");
  chk_law_gate: assert property (@(posedge clk) disable iff (srst) // [RQ2]
    !coding_conversion_enable |-> coding_law == 5'h00)
    else $error("law used while disabled");
  chk_enable_kept: assert property (@(posedge clk) disable iff (srst) // [RQ15]
    $fell(fill_busy) && !ctrl_wr |=> fill_en == $past(fill_en))
    else $error("fill enable changed by device");
endmodule : cm_fill
`default_nettype wire

/* testbench/host.sv */
// Purpose: host processor model on the memory and control port
// Assumes: drives after falling edges, holds cs until ack
// Notes: released write data shows its inverse, not the old value
`timescale 1ns/100ps
`default_nettype none
module host (
  input wire logic clk,
  input wire logic ack,
  input wire logic [15:0] rdata,
  output logic cs,
  output logic wr,
  output logic high_sel,
  output logic [10:0] addr,
  output logic [15:0] wdata,
  output logic ctrl_wr,
  output logic mode_wr,
  output logic [15:0] ctrl_wdata,
  output logic [15:0] mode_wdata
);
  initial begin
    {cs, wr, high_sel, addr, wdata, ctrl_wr, mode_wr} = '0;
    {ctrl_wdata, mode_wdata} = '0;
  end
  // high word before coding enable, reserved bits zero
  task automatic xfer(input logic w, h, input logic [10:0] a,
                      input logic [15:0] d, output logic [15:0] q);
    @(negedge clk);
    {cs, wr, high_sel, addr, wdata} = {1'b1, w, h, a, d};
    q = 'x;
    for (int n = 0; n < 8; n++) begin
      @(posedge clk);
      if (ack === 1'b1) begin
        q = rdata;
        break;
      end
    end
    @(negedge clk);
    cs = 1'b0;
    wdata = ~wdata;
  endtask : xfer
  // m low: control, m high: mode
  task automatic set_reg(input logic m, input logic [15:0] d);
    @(negedge clk);
    {ctrl_wdata, mode_wdata} = {d, d};
    {mode_wr, ctrl_wr} = {m, ~m};
    @(negedge clk);
    {mode_wr, ctrl_wr} = 2'b00;
  endtask : set_reg
endmodule : host
`default_nettype wire

/* testbench/tb_top.sv */
// Purpose: self-checking bench for connection memory and block fill
// Assumes: fill shortened to 2100 cycles
// Notes: table rows, then fill, refused start and both aborts
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int FILL = 2100;
  logic clk, srst, cs, wr, high_sel, ack, ctrl_wr, mode_wr, fill_busy;
  logic special_mode_select, coding_conversion_enable, variable_delay;
  logic [10:0] addr, chan_sel, a;
  logic [15:0] wdata, rdata, ctrl_wdata, mode_wdata, q, lo;
  logic [15:0] main_control_register, internal_mode_register;
  logic [7:0] source_channel_field, message_byte_field;
  logic [4:0] source_stream_field, coding_law, hi;
  int n_mismatch = 0;
  int num_checks = 0;
  int cnt;
  // address, low word, high word: variable delay, constant, message
  logic [31:0] rows [3] = '{{11'h005, 16'hda52, 5'h15},
    {11'h7ff, 16'h07f8, 5'h0a}, {11'h000, 16'hc3a7, 5'h1f}};
  cm_fill #(.FILL_CYC(FILL)) cm_fill_i (.clk, .srst, .cs, .wr, .high_sel,
    .addr, .wdata, .rdata, .ack, .ctrl_wr, .ctrl_wdata, .mode_wr,
    .mode_wdata, .main_control_register, .internal_mode_register,
    .chan_sel, .special_mode_select, .source_channel_field,
    .source_stream_field, .message_byte_field, .coding_conversion_enable,
    .coding_law, .variable_delay, .fill_busy);
  host host_i (.clk, .ack, .rdata, .cs, .wr, .high_sel, .addr, .wdata,
    .ctrl_wr, .mode_wr, .ctrl_wdata, .mode_wdata);
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // run needs some 2200 cycles; the limit leaves wide margin
  initial begin
    #400000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    srst = 1'b1;
    chan_sel = '0;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    chk(internal_mode_register, 16'h0);
    host_i.set_reg(1'b0, 16'h0010);
    foreach (rows[i]) begin
      {a, lo, hi} = rows[i];
      host_i.xfer(1'b1, 1'b1, a, {11'h0, hi}, q);
      host_i.xfer(1'b1, 1'b0, a, lo, q);
      host_i.xfer(1'b0, 1'b0, a, 16'h0, q);
      chk(q, lo);
      host_i.xfer(1'b0, 1'b1, a, 16'h0, q);
      chk(q, {11'h0, hi});
      chan_sel = a;
      repeat (2) @(negedge clk);
      chk(16'(special_mode_select), 16'(lo[0]));
      chk(16'(source_channel_field), 16'(lo[8:1]));
      chk(16'(source_stream_field), 16'(lo[13:9]));
      chk(16'(message_byte_field), 16'(lo[10:3]));
      chk(16'(coding_conversion_enable), 16'(lo[15]));
      chk(16'(coding_law), lo[15] ? 16'(hi) : 16'h0);
      chk(16'(variable_delay), 16'(lo[14] & ~lo[0]));
    end
    host_i.set_reg(1'b0, 16'h0018);
    host_i.set_reg(1'b1, 16'h000b);
    @(negedge clk);
    cnt = 1;
    while (fill_busy === 1'b1 && cnt < 3000) begin
      @(negedge clk);
      cnt++;
    end
    chk(16'(cnt > FILL && cnt < 3000), 16'h1);
    chk(internal_mode_register, 16'h000a);
    chk(main_control_register, 16'h0018);
    foreach (rows[i]) begin
      host_i.xfer(1'b0, 1'b0, rows[i][31:21], 16'h0, q);
      chk(q, 16'h0005);
      host_i.xfer(1'b0, 1'b1, rows[i][31:21], 16'h0, q);
      chk(q, 16'h0);
    end
    host_i.set_reg(1'b0, 16'h0);
    host_i.set_reg(1'b1, 16'h0003);
    chk(internal_mode_register, 16'h0002);
    repeat (8) @(negedge clk);
    chk(16'(fill_busy), 16'h0);
    host_i.xfer(1'b0, 1'b0, 11'h005, 16'h0, q);
    chk(q, 16'h0005);
    // first pass drops enable, second drops start
    for (int k = 0; k < 2; k++) begin
      host_i.set_reg(1'b0, 16'h0008);
      host_i.set_reg(1'b1, 16'h0001);
      @(negedge clk);
      chk(16'(fill_busy), 16'h1);
      host_i.set_reg(k[0], 16'h0);
      @(negedge clk);
      chk(16'(fill_busy), 16'h0);
      host_i.set_reg(1'b1, 16'h0);
    end
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
